// *** logic/spc_serial_cfg.sv ***
// Serial port configuration, software reset, recovery and multiplier reprogramming
`timescale 1ns/100ps
module spc_serial_cfg #(
	parameter int MULT_W = spc_pkg::CFG_MULT_W
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire spc_pkg::spc_wr_t reg_wr,
	input wire logic serial_data_out_pin_tx_data,
	input wire logic serial_data_out_pin_tx_en,
	input wire logic single_resistor_mode,
	input wire logic [spc_pkg::SAMPLE_W-1:0] in_phase_sample,
	input wire logic [spc_pkg::SAMPLE_W-1:0] quadrature_sample,
	output spc_pkg::spc_cfg_t port_cfg,
	output logic sw_reset_pulse,
	output logic [MULT_W-1:0] oscillator_input_multiplier,
	output logic system_clock_settled,
	output logic recovery_armed,
	output logic in_phase_offset_to_complement,
	output logic quadrature_offset_to_complement,
	output logic ref_split_single,
	output logic serial_data_out_pin_o,
	output logic serial_data_out_pin_oe,
	output logic [spc_pkg::THERM_HI_W-1:0] i_therm_hi,
	output logic [spc_pkg::THERM_MID_W-1:0] i_therm_mid,
	output logic [spc_pkg::SEG_LO_W-1:0] i_bin_lo,
	output logic [spc_pkg::THERM_HI_W-1:0] q_therm_hi,
	output logic [spc_pkg::THERM_MID_W-1:0] q_therm_mid,
	output logic [spc_pkg::SEG_LO_W-1:0] q_bin_lo
);

	// ==========================================================
	// Decode helpers
	// Pattern reads the same either way round, so it survives a lost bit order
	function automatic logic is_recovery(input logic [7:0] d);
		return (d[0] == d[7]) && (d[1] == d[6]) && d[2] && d[5] && !d[3] && !d[4];
	endfunction

	function automatic logic is_wr(input spc_pkg::spc_wr_t w, input logic [4:0] a);
		return w.strb && (w.addr == a);
	endfunction

	spc_pkg::spc_state_t state;
	spc_pkg::spc_state_t next_state;
	spc_pkg::spc_cfg_t next_port_cfg;
	logic next_sw_reset_pulse;
	logic [MULT_W-1:0] next_mult;
	logic [7:0] settle_cnt;
	logic [7:0] next_settle_cnt;
	logic next_settled;
	logic next_ofs_i;
	logic next_ofs_q;
	logic next_ref_split;
	logic next_out_data;
	logic next_out_oe;
	logic wr_cfg;
	logic wr_ofs_i;
	logic wr_ofs_q;
	logic soft_rst;
	logic mult_load;

	// ==========================================================
	// Write classification
	always_comb begin
		wr_cfg = is_wr(reg_wr, spc_pkg::REG_CFG_ADDR);
		wr_ofs_i = is_wr(reg_wr, spc_pkg::REG_OFS_I_ADDR);
		wr_ofs_q = is_wr(reg_wr, spc_pkg::REG_OFS_Q_ADDR);
		soft_rst = wr_cfg && reg_wr.data[spc_pkg::CFG_SW_RESET_BIT];
		mult_load = (state == spc_pkg::SPC_ARMED) && wr_cfg
			&& !reg_wr.data[spc_pkg::CFG_SW_RESET_BIT]
			&& (reg_wr.data[7:6] == {port_cfg.bidir, port_cfg.lsb_first});
	end

	// ==========================================================
	// Configuration register; the reset bit is never stored
	always_comb begin
		next_port_cfg = port_cfg;
		next_sw_reset_pulse = soft_rst;
		if (wr_cfg) begin
			// Takes effect on the byte's own strobe, mid-cycle included
			next_port_cfg.bidir = reg_wr.data[spc_pkg::CFG_BIDIR_BIT];
			next_port_cfg.lsb_first = reg_wr.data[spc_pkg::CFG_LSB_FIRST_BIT];
			next_port_cfg.low = reg_wr.data[spc_pkg::CFG_LOW_W-1:0];
		end
	end

	// ==========================================================
	// Offset steering; soft reset returns these to default
	always_comb begin
		next_ofs_i = in_phase_offset_to_complement;
		next_ofs_q = quadrature_offset_to_complement;
		if (soft_rst) begin
			next_ofs_i = spc_pkg::OFS_STEER_RST;
			next_ofs_q = spc_pkg::OFS_STEER_RST;
		end else begin
			if (wr_ofs_i) begin
				next_ofs_i = reg_wr.data[spc_pkg::OFS_STEER_BIT];
			end
			if (wr_ofs_q) begin
				next_ofs_q = reg_wr.data[spc_pkg::OFS_STEER_BIT];
			end
		end
	end

	// ==========================================================
	// Recovery sequence and multiplier settling
	always_comb begin
		next_state = state;
		next_mult = oscillator_input_multiplier;
		next_settle_cnt = (settle_cnt != 8'h00) ? settle_cnt - 8'h01 : 8'h00;
		case (state)
			spc_pkg::SPC_IDLE: begin
				if (wr_cfg && is_recovery(reg_wr.data)) begin
					next_state = spc_pkg::SPC_ARMED;
				end
			end
			spc_pkg::SPC_ARMED: begin
				if (mult_load) begin
					next_mult = reg_wr.data[spc_pkg::CFG_MULT_LSB +: MULT_W];
					next_settle_cnt = spc_pkg::SETTLE_CNT;
					next_state = spc_pkg::SPC_IDLE;
				end else if (wr_cfg && !is_recovery(reg_wr.data)) begin
					// Any other write to the register, except a repeated recovery pattern, breaks the sequence
					next_state = spc_pkg::SPC_IDLE;
				end
			end
			default: begin
				next_state = spc_pkg::SPC_IDLE;
			end
		endcase
		next_settled = (next_settle_cnt == 8'h00);
	end

	// ==========================================================
	// Pins and analog selections
	always_comb begin
		next_out_data = serial_data_out_pin_tx_data;
		// Follows the new mode on the same edge, so no stray drive after a switch
		next_out_oe = serial_data_out_pin_tx_en && !next_port_cfg.bidir;
		next_ref_split = single_resistor_mode;
	end

	// ==========================================================
	// State registers
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state <= spc_pkg::SPC_IDLE;
			port_cfg <= '{bidir: spc_pkg::CFG_BIDIR_RST, lsb_first: spc_pkg::CFG_LSB_FIRST_RST,
				low: spc_pkg::CFG_LOW_RST};
			sw_reset_pulse <= 1'b0;
			oscillator_input_multiplier <= MULT_W'(spc_pkg::MULT_RST);
			settle_cnt <= 8'h00;
			system_clock_settled <= 1'b1;
			recovery_armed <= 1'b0;
			in_phase_offset_to_complement <= spc_pkg::OFS_STEER_RST;
			quadrature_offset_to_complement <= spc_pkg::OFS_STEER_RST;
			ref_split_single <= 1'b0;
			serial_data_out_pin_o <= 1'b0;
			serial_data_out_pin_oe <= 1'b0;
		end else begin
			state <= next_state;
			port_cfg <= next_port_cfg;
			sw_reset_pulse <= next_sw_reset_pulse;
			oscillator_input_multiplier <= next_mult;
			settle_cnt <= next_settle_cnt;
			system_clock_settled <= next_settled;
			recovery_armed <= (next_state == spc_pkg::SPC_ARMED);
			in_phase_offset_to_complement <= next_ofs_i;
			quadrature_offset_to_complement <= next_ofs_q;
			ref_split_single <= next_ref_split;
			serial_data_out_pin_o <= next_out_data;
			serial_data_out_pin_oe <= next_out_oe;
		end
	end

	// ==========================================================
	// Sample decoders, one per channel
	spc_seg_decoder #(.SAMPLE_W(spc_pkg::SAMPLE_W)) u_dec_i (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.sample(in_phase_sample),
		.therm_hi(i_therm_hi),
		.therm_mid(i_therm_mid),
		.bin_lo(i_bin_lo)
	);

	spc_seg_decoder #(.SAMPLE_W(spc_pkg::SAMPLE_W)) u_dec_q (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.sample(quadrature_sample),
		.therm_hi(q_therm_hi),
		.therm_mid(q_therm_mid),
		.bin_lo(q_bin_lo)
	);

	// ==========================================================
	// Assertions
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	AST_CFG_APPLY: assert property (wr_cfg |=> (port_cfg.bidir == $past(reg_wr.data[7]))
		&& (port_cfg.lsb_first == $past(reg_wr.data[6])))
		else $error("Port configuration not applied one cycle after its write");

	AST_CFG_HOLD: assert property (!wr_cfg |=> $stable(port_cfg))
		else $error("Configuration register changed without a write to it");

	AST_SOFT_RESET: assert property (soft_rst |=> sw_reset_pulse
		&& !in_phase_offset_to_complement && !quadrature_offset_to_complement)
		else $error("Software reset did not default the other registers");

	AST_RESET_SELF_CLEAR: assert property (sw_reset_pulse |-> $past(soft_rst))
		else $error("Reset pulse without a reset write");

	AST_RECOVERY_ARMS: assert property ((wr_cfg && is_recovery(reg_wr.data))
		|=> recovery_armed && sw_reset_pulse)
		else $error("Recovery write did not arm and reset");

	AST_MULT_LOAD: assert property (mult_load |=>
		(oscillator_input_multiplier == $past(reg_wr.data[3:2])) && !system_clock_settled)
		else $error("Multiplier not reprogrammed after recovery");

	AST_SETTLE_BOUND: assert property ($fell(system_clock_settled) |-> ##[1:200] system_clock_settled)
		else $error("System clock not settled within 200 cycles");

	AST_SETTLE_LOW: assert property ($fell(system_clock_settled) |-> !system_clock_settled[*8])
		else $error("Settled flag rose too early");

	AST_OFS_STEER: assert property ((wr_ofs_i && !soft_rst) |=>
		in_phase_offset_to_complement == $past(reg_wr.data[7]))
		else $error("In-phase offset steering not updated");

	AST_OUT_PIN_QUIET: assert property (port_cfg.bidir |-> !serial_data_out_pin_oe)
		else $error("Data-out pin driven in bidirectional mode");

	AST_REF_MODE: assert property (##1 ref_split_single == $past(single_resistor_mode))
		else $error("Reference mode not followed");

endmodule

// *** inc/spc_pkg.sv ***
// Constants and types shared by the serial port configuration and reset block
package spc_pkg;

	// ==========================================================
	// Register addresses
	localparam logic [4:0] REG_CFG_ADDR = 5'h00;
	localparam logic [4:0] REG_OFS_I_ADDR = 5'h08;
	localparam logic [4:0] REG_OFS_Q_ADDR = 5'h0c;

	// ==========================================================
	// Field positions in the configuration and offset registers
	localparam int CFG_BIDIR_BIT = 7;
	localparam int CFG_LSB_FIRST_BIT = 6;
	localparam int CFG_SW_RESET_BIT = 5;
	localparam int CFG_MULT_LSB = 2;
	localparam int CFG_MULT_W = 2;
	localparam int CFG_LOW_W = 5;
	localparam int OFS_STEER_BIT = 7;

	// ==========================================================
	// Reset values
	localparam logic CFG_BIDIR_RST = 1'b0;
	localparam logic CFG_LSB_FIRST_RST = 1'b0;
	localparam logic [4:0] CFG_LOW_RST = 5'h00;
	localparam logic OFS_STEER_RST = 1'b0;
	localparam logic [1:0] MULT_RST = 2'h0;

	// ==========================================================
	// Timing: the system clock settles within this many master clock cycles
	localparam int SETTLE_CYCLES = 200;
	localparam logic [7:0] SETTLE_CNT = 8'(SETTLE_CYCLES);

	// ==========================================================
	// Sample decoder segmentation
	localparam int SAMPLE_W = 14;
	localparam int SEG_HI_W = 5;
	localparam int SEG_MID_W = 4;
	localparam int SEG_LO_W = 5;
	localparam int THERM_HI_W = 31;
	localparam int THERM_MID_W = 15;

	// ==========================================================
	// Types
	typedef struct packed {
		logic strb;
		logic [4:0] addr;
		logic [7:0] data;
	} spc_wr_t;

	typedef struct packed {
		logic bidir;
		logic lsb_first;
		logic [4:0] low;
	} spc_cfg_t;

	typedef enum logic [1:0] {
		SPC_IDLE = 2'b01,
		SPC_ARMED = 2'b10
	} spc_state_t;

endpackage

// *** logic/spc_seg_decoder.sv ***
// Segmented current-switch decoder for one channel sample
`timescale 1ns/100ps
module spc_seg_decoder #(
	parameter int SAMPLE_W = spc_pkg::SAMPLE_W
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [SAMPLE_W-1:0] sample,
	output logic [spc_pkg::THERM_HI_W-1:0] therm_hi,
	output logic [spc_pkg::THERM_MID_W-1:0] therm_mid,
	output logic [spc_pkg::SEG_LO_W-1:0] bin_lo
);

	// ==========================================================
	// Thermometer code, shared by both unary segments
	function automatic logic [spc_pkg::THERM_HI_W-1:0] therm(input logic [4:0] val);
		logic [spc_pkg::THERM_HI_W-1:0] t;
		t = '0;
		for (int k = 0; k < spc_pkg::THERM_HI_W; k++) begin
			t[k] = (5'(k) < val);
		end
		return t;
	endfunction

	logic [spc_pkg::THERM_HI_W-1:0] next_therm_hi;
	logic [spc_pkg::THERM_MID_W-1:0] next_therm_mid;
	logic [spc_pkg::SEG_LO_W-1:0] next_bin_lo;
	logic [spc_pkg::THERM_HI_W-1:0] mid_full;

	// ==========================================================
	// Split 5-4-5: unary top, unary middle, binary bottom
	always_comb begin
		mid_full = therm({1'b0, sample[SAMPLE_W-spc_pkg::SEG_HI_W-1 -: spc_pkg::SEG_MID_W]});
		next_therm_hi = therm(sample[SAMPLE_W-1 -: spc_pkg::SEG_HI_W]);
		next_therm_mid = mid_full[spc_pkg::THERM_MID_W-1:0];
		next_bin_lo = sample[spc_pkg::SEG_LO_W-1:0];
	end

	// Registered so switch drivers see glitch-free patterns
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			therm_hi <= '0;
			therm_mid <= '0;
			bin_lo <= '0;
		end else begin
			therm_hi <= next_therm_hi;
			therm_mid <= next_therm_mid;
			bin_lo <= next_bin_lo;
		end
	end

	AST_SEG_WEIGHTS: assert property (@(posedge core_clk) disable iff (!rst_b)
		##1 ($countones(therm_hi) == 32'($past(sample[13:9])))
		&& ($countones(therm_mid) == 32'($past(sample[8:5])))
		&& (bin_lo == $past(sample[4:0])))
		else $error("Segmented decode does not match sample");

endmodule

// *** tb/spc_host_model.sv ***
// Host-side model presenting completed register byte writes to the block
`timescale 1ns/100ps
module spc_host_model (
	input wire logic core_clk,
	output spc_pkg::spc_wr_t reg_wr
);
	// ==========================================================
	// Idle bus
	// Stale address and data are inverted so a missed strobe cannot match
	initial begin
		reg_wr = '{strb: 1'b0, addr: 5'h1f, data: 8'h5a};
	end

	// ==========================================================
	// Byte write
	// One whole byte per call, so a config change or reset goes alone
	task automatic write_byte(input logic [4:0] addr, input logic [7:0] data);
		@(negedge core_clk);
		reg_wr <= '{strb: 1'b1, addr: addr, data: data};
		@(negedge core_clk);
		reg_wr <= '{strb: 1'b0, addr: ~addr, data: ~data};
	endtask
endmodule

// *** tb/test_serial_port_config_reset.sv ***
// Self-checking bench for the serial port configuration and reset block
`timescale 1ns/100ps
module test_serial_port_config_reset;
	// ==========================================================
	// Stimulus and observed signals
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	spc_pkg::spc_wr_t reg_wr;
	logic tx_data = 1'b0;
	logic tx_en = 1'b0;
	logic single_resistor_mode = 1'b0;
	logic [13:0] in_phase_sample = 14'h0000;
	logic [13:0] quadrature_sample = 14'h0000;
	spc_pkg::spc_cfg_t port_cfg;
	logic sw_reset_pulse;
	logic [1:0] mult;
	logic settled;
	logic armed;
	logic i_ofs;
	logic q_ofs;
	logic ref_split;
	logic pin_o;
	logic pin_oe;
	logic [30:0] i_hi;
	logic [14:0] i_mid;
	logic [4:0] i_lo;
	logic [30:0] q_hi;
	logic [14:0] q_mid;
	logic [4:0] q_lo;
	int fails = 0;
	int check_count = 0;
	int n;
	logic [13:0] smp [3] = '{14'h0000, 14'h3fff, 14'h2a35};

	// Free-running 25 MHz clock
	always #20 core_clk = ~core_clk;

	// ==========================================================
	// Instances
	spc_host_model u_spc_host_model (.core_clk(core_clk), .reg_wr(reg_wr));
	spc_serial_cfg u_spc_serial_cfg (.core_clk(core_clk), .rst_b(rst_b), .reg_wr(reg_wr),
		.serial_data_out_pin_tx_data(tx_data), .serial_data_out_pin_tx_en(tx_en),
		.single_resistor_mode(single_resistor_mode),
		.in_phase_sample(in_phase_sample), .quadrature_sample(quadrature_sample), .port_cfg(port_cfg),
		.sw_reset_pulse(sw_reset_pulse), .oscillator_input_multiplier(mult), .system_clock_settled(settled),
		.recovery_armed(armed), .in_phase_offset_to_complement(i_ofs),
		.quadrature_offset_to_complement(q_ofs), .ref_split_single(ref_split),
		.serial_data_out_pin_o(pin_o), .serial_data_out_pin_oe(pin_oe), .i_therm_hi(i_hi),
		.i_therm_mid(i_mid), .i_bin_lo(i_lo), .q_therm_hi(q_hi), .q_therm_mid(q_mid), .q_bin_lo(q_lo));

	// ==========================================================
	// Helpers
	// Four-state compare so an unknown never passes
	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
		end
	endtask

	// Thermometer code with n ones from bit 0 upward
	function automatic logic [63:0] therm(input int n);
		return (64'h1 << n) - 64'h1;
	endfunction

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		u_spc_host_model.write_byte(a, d);
	endtask

	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Watchdog sized well beyond the roughly 870 cycles the tests need
	initial begin
		#400000;
		fails++;
		$display("ERROR at %0t: watchdog expired", $time);
		summarize();
	end

	// ==========================================================
	// Test sequence
	initial begin
		repeat (10) @(negedge core_clk);
		rst_b = 1'b1;
		chk(port_cfg, 7'h00, "reset cfg");
		chk({sw_reset_pulse, mult, settled, armed, i_ofs, q_ofs, pin_oe}, 8'h10, "reset flags");
		// Offset steering per channel, plus an unmapped write that must be ignored
		wr(5'h08, 8'h80);
		chk({i_ofs, q_ofs}, 2'b10, "i offset");
		wr(5'h0c, 8'h80);
		chk({i_ofs, q_ofs}, 2'b11, "q offset");
		wr(5'h05, 8'hff);
		chk({port_cfg, i_ofs, q_ofs}, 9'h003, "unmapped");
		// Both port config bits together; applied right after the byte
		wr(5'h00, 8'hc0);
		chk({port_cfg, sw_reset_pulse}, 8'hc0, "cfg write");
		// Separate output pin stays undriven in bidirectional mode
		tx_en = 1'b1;
		tx_data = 1'b1;
		@(negedge core_clk);
		chk(pin_oe, 1'b0, "oe bidir");
		wr(5'h00, 8'h00);
		chk({pin_oe, pin_o}, 2'b11, "oe unidir");
		wr(5'h00, 8'h80);
		chk(pin_oe, 1'b0, "oe same cycle");
		tx_en = 1'b0;
		// Soft reset clears other registers; register 0x00 takes the other bits of the written byte
		wr(5'h00, 8'h60);
		chk({port_cfg, sw_reset_pulse, i_ofs, q_ofs}, 10'h104, "soft reset");
		@(negedge core_clk);
		chk(sw_reset_pulse, 1'b0, "pulse self-clear");
		// Recovery then multiplier load, for every bit-order and pin combination
		for (int xy = 0; xy < 4; xy++) begin
			wr(5'h08, 8'h80);
			wr(5'h00, {xy[1], xy[0], 4'b1001, xy[0], xy[1]});
			chk({port_cfg.bidir, port_cfg.lsb_first, sw_reset_pulse, armed, i_ofs}, {xy[1:0], 3'b110},
				"recovery");
			wr(5'h00, {xy[1], xy[0], 2'b00, 2'(3 - xy), 2'b00});
			chk({mult, armed, settled}, {2'(3 - xy), 2'b00}, "mult load");
			n = 0;
			while (settled !== 1'b1 && n < 300) begin
				@(negedge core_clk);
				n++;
			end
			chk(n, 200, "settle span");
		end
		// Multiplier write without a preceding recovery is ignored, even with matching XY
		wr(5'h00, 8'hcc);
		chk(mult, 2'b00, "mult refused");
		// A mismatched follow-up breaks the sequence, so a matching retry is refused too
		wr(5'h00, 8'ha5);
		wr(5'h00, 8'h0c);
		chk({mult, armed}, 3'b000, "mismatch disarms");
		wr(5'h00, 8'h0c);
		chk(mult, 2'b00, "retry refused");
		// A repeated recovery keeps the sequence armed for the multiplier write
		wr(5'h00, 8'ha5);
		wr(5'h00, 8'ha5);
		chk(armed, 1'b1, "rearm holds");
		wr(5'h00, 8'h88);
		chk({mult, armed}, 3'b100, "mult after rearm");
		// Reference mode selection follows the input one cycle later
		single_resistor_mode = 1'b1;
		@(negedge core_clk);
		chk(ref_split, 1'b1, "single mode");
		single_resistor_mode = 1'b0;
		@(negedge core_clk);
		chk(ref_split, 1'b0, "dual mode");
		// Boundary and mixed sample codes, quadrature gets the inverse
		for (int k = 0; k < 3; k++) begin
			in_phase_sample = smp[k];
			quadrature_sample = ~smp[k];
			@(negedge core_clk);
			chk(i_hi, therm(smp[k][13:9]), "i hi");
			chk(i_mid, therm(smp[k][8:5]), "i mid");
			chk(i_lo, smp[k][4:0], "i lo");
			chk(q_hi, therm(5'(~smp[k][13:9])), "q hi");
			chk(q_mid, therm(4'(~smp[k][8:5])), "q mid");
			chk(q_lo, 5'(~smp[k][4:0]), "q lo");
		end
		summarize();
	end
endmodule
